// ===== inc/hci_pkg.sv
package hci_pkg;

	// =========================================
	// register offsets and reset values
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_VEC = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] HS_ACCEPT = 8'hfe;
	localparam logic [7:0] HS_READY = 8'hff;
	localparam logic [7:0] VEC_RESET = 8'h0f;
	localparam int UNDEFINED_INSTRUCTION_FLAG_BIT = 0;
	localparam logic [31:0] FSB_BYTES_DEF = 32'h00000010;

	// =========================================
	// command codes
	localparam logic [7:0] CMD_LOAD_FUNCTION_CODE_CMD = 8'h80;
	localparam logic [7:0] CMD_LOAD_STATION_POINTER_CMD = 8'h81;
	localparam logic [7:0] CMD_LOAD_TTP = 8'h85;
	localparam logic [7:0] CMD_UPDATE = 8'h88;
	localparam logic [7:0] CMD_CLR_TX = 8'h89;
	localparam logic [7:0] CMD_CLR_RX = 8'h8a;
	localparam logic [7:0] CMD_CLR_ALL = 8'h8b;
	localparam logic [7:0] CMD_DUMP_PAR = 8'h8c;
	localparam logic [7:0] CMD_START = 8'h8d;
	localparam logic [7:0] CMD_STOP = 8'h8e;
	localparam logic [7:0] CMD_DUMP_REG = 8'h8f;
	localparam logic [7:0] CMD_DMA = 8'h90;
	localparam logic [7:0] CMD_LOOP = 8'h91;
	localparam logic [7:0] CMD_MON = 8'h92;
	localparam logic [7:0] CMD_END_MON = 8'h93;
	localparam logic [7:0] CMD_CONT_TX = 8'h95;
	localparam logic [7:0] CMD_SW_RESET = 8'hff;
	localparam logic [3:0] GRP_LOAD = 4'h8;
	localparam logic [2:0] GRP_STN = 3'h5;
	localparam logic [2:0] GRP_HW = 3'h6;

	// =========================================
	// vector sources
	localparam logic [1:0] SRC_BOTH = 2'h0;
	localparam logic [1:0] SRC_RX = 2'h1;
	localparam logic [1:0] SRC_TX = 2'h2;
	localparam logic [1:0] SRC_FATAL = 2'h3;

	// =========================================
	// station table words (16-bit) and dump area
	localparam logic [5:0] W_TTP_HI = 6'h0e;
	localparam logic [5:0] W_TTP_LO = 6'h0f;
	localparam logic [5:0] W_TXP_HI = 6'h10;
	localparam logic [5:0] W_TXP_LO = 6'h11;
	localparam logic [5:0] W_UNACK_HI = 6'h12;
	localparam logic [5:0] W_UNACK_LO = 6'h13;
	localparam logic [5:0] W_RX_CLR = 6'h14;
	localparam logic [5:0] W_TX_CLR = 6'h15;
	localparam logic [5:0] W_RX_STAT = 6'h16;
	localparam logic [5:0] W_TX_STAT = 6'h17;
	localparam logic [5:0] W_DUMP = 6'h20;

	// =========================================
	// data selectors for table transfers
	localparam logic [3:0] S_CUR_HI = 4'h0;
	localparam logic [3:0] S_CUR_LO = 4'h1;
	localparam logic [3:0] S_UNACK_HI = 4'h2;
	localparam logic [3:0] S_UNACK_LO = 4'h3;
	localparam logic [3:0] S_BASE_HI = 4'h4;
	localparam logic [3:0] S_BASE_LO = 4'h5;
	localparam logic [3:0] S_SPACE = 4'h6;
	localparam logic [3:0] S_RX = 4'h7;
	localparam logic [3:0] S_TX = 4'h8;
	localparam logic [3:0] S_RX_CLR = 4'h9;
	localparam logic [3:0] S_TX_CLR = 4'ha;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_load = 2'b01,
		st_mem = 2'b11,
		st_done = 2'b10
	} cmd_state_t;

endpackage

// ===== hw/host_command_interface.sv
`timescale 1ns/1ps
module host_command_interface #(
	parameter logic [31:0] FSB_BYTES = hci_pkg::FSB_BYTES_DEF
) (
	// clock, reset, enable
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// shared memory port, 16-bit words
	output logic mem_req_out,
	output logic mem_we_out,
	output logic [31:0] mem_addr_out,
	output logic [15:0] mem_wdata_out,
	output logic [3:0] mem_space_out,
	input wire logic mem_ack_in,
	input wire logic [15:0] mem_rdata_in,
	input wire logic mem_err_in,
	// link engine events
	input wire logic frame_sent_in,
	input wire logic ack_valid_in,
	input wire logic [2:0] ack_nr_in,
	input wire logic [7:0] rx_event_in,
	input wire logic [7:0] tx_event_in,
	// host interrupt
	input wire logic iack_in,
	output logic irq_out,
	output logic [7:0] vector_out,
	// configuration to link engine
	output logic [1:0] station_cfg_out,
	output logic [3:0] hw_cfg_out,
	output logic link_up_out,
	output logic loopback_out,
	output logic monitor_out,
	output logic dma_go_out,
	output logic continue_tx_out
);

	// =========================================
	// decode helpers
	function automatic logic cmd_valid(input logic [7:0] c);
		cmd_valid = (c[7:4] == hci_pkg::GRP_LOAD)
			|| (c >= hci_pkg::CMD_DMA && c <= hci_pkg::CMD_END_MON)
			|| (c == hci_pkg::CMD_CONT_TX) || (c == hci_pkg::CMD_SW_RESET)
			|| (c[7:5] == hci_pkg::GRP_STN) || (c[7:5] == hci_pkg::GRP_HW);
	endfunction

	// table program: {last, write, word, selector}; zero means no table traffic
	function automatic logic [11:0] prog(input logic [7:0] c, input logic [2:0] s);
		prog = 12'h000;
		case (c)
			hci_pkg::CMD_LOAD_TTP: begin
				if (s == 3'h0) prog = {2'b00, hci_pkg::W_TTP_HI, hci_pkg::S_CUR_HI};
				if (s == 3'h1) prog = {2'b10, hci_pkg::W_TTP_LO, hci_pkg::S_CUR_LO};
			end
			hci_pkg::CMD_DUMP_PAR: begin
				if (s == 3'h0) prog = {2'b01, hci_pkg::W_TXP_HI, hci_pkg::S_CUR_HI};
				if (s == 3'h1) prog = {2'b01, hci_pkg::W_TXP_LO, hci_pkg::S_CUR_LO};
				if (s == 3'h2) prog = {2'b01, hci_pkg::W_UNACK_HI, hci_pkg::S_UNACK_HI};
				if (s == 3'h3) prog = {2'b11, hci_pkg::W_UNACK_LO, hci_pkg::S_UNACK_LO};
			end
			hci_pkg::CMD_DUMP_REG: begin
				prog = {1'b0, 1'b1, 6'(hci_pkg::W_DUMP + {3'h0, s}), 4'(s + 3'h4)};
				if (s == 3'h3) prog = {2'b01, 6'(hci_pkg::W_DUMP + 6'h3), hci_pkg::S_CUR_HI};
				if (s == 3'h4) prog = {2'b11, 6'(hci_pkg::W_DUMP + 6'h4), hci_pkg::S_CUR_LO};
			end
			hci_pkg::CMD_UPDATE: begin
				if (s == 3'h0) prog = {2'b01, hci_pkg::W_RX_STAT, hci_pkg::S_RX};
				if (s == 3'h1) prog = {2'b11, hci_pkg::W_TX_STAT, hci_pkg::S_TX};
			end
			hci_pkg::CMD_CLR_TX: begin
				if (s == 3'h0) prog = {2'b00, hci_pkg::W_TX_CLR, hci_pkg::S_TX_CLR};
				if (s == 3'h1) prog = {2'b11, hci_pkg::W_TX_STAT, hci_pkg::S_TX};
			end
			hci_pkg::CMD_CLR_RX: begin
				if (s == 3'h0) prog = {2'b00, hci_pkg::W_RX_CLR, hci_pkg::S_RX_CLR};
				if (s == 3'h1) prog = {2'b11, hci_pkg::W_RX_STAT, hci_pkg::S_RX};
			end
			hci_pkg::CMD_CLR_ALL: begin
				if (s == 3'h0) prog = {2'b00, hci_pkg::W_RX_CLR, hci_pkg::S_RX_CLR};
				if (s == 3'h1) prog = {2'b00, hci_pkg::W_TX_CLR, hci_pkg::S_TX_CLR};
				if (s == 3'h2) prog = {2'b01, hci_pkg::W_RX_STAT, hci_pkg::S_RX};
				if (s == 3'h3) prog = {2'b11, hci_pkg::W_TX_STAT, hci_pkg::S_TX};
			end
			default: prog = 12'h000;
		endcase
	endfunction

	// =========================================
	// state
	hci_pkg::cmd_state_t state;
	logic [7:0] cmd;
	logic [2:0] step;
	logic [11:0] op;
	logic [7:0] handshake;
	logic [7:0] iv;
	logic iv_written;
	logic [31:0] init_value;
	logic [31:0] base;
	logic [3:0] space;
	logic [31:0] cursor;
	logic [2:0] sent_count;
	logic [2:0] last_nr;
	logic [7:0] rx_status;
	logic [7:0] tx_status;
	logic fatal;
	logic iack_meta;
	logic iack_sync;
	logic iack_prev;

	logic acc;
	logic wr_acc;
	logic mapped;
	logic cmd_go;
	logic sw_rst;
	logic rst_all;
	logic mem_done;
	logic [31:0] unack;
	logic [15:0] src_word;
	logic [1:0] src;
	logic cursor_load;
	wire logic [11:0] next_op = prog(cmd, step);
	wire logic [3:0] word_sel = (state == hci_pkg::st_load) ? next_op[3:0] : op[3:0];

	assign mapped = (paddr_in == hci_pkg::OFF_CMD) || (paddr_in == hci_pkg::OFF_VEC)
		|| (paddr_in == hci_pkg::OFF_DATA) || (paddr_in == hci_pkg::OFF_STAT);
	assign acc = psel_in && penable_in && ce_in;
	assign wr_acc = acc && pwrite_in && mapped;
	// a command arriving while busy is dropped: the host must wait for ready
	assign cmd_go = wr_acc && (paddr_in == hci_pkg::OFF_CMD) && (state == hci_pkg::st_idle);
	assign sw_rst = cmd_go && (pwdata_in[7:0] == hci_pkg::CMD_SW_RESET);
	assign rst_all = rst_in || sw_rst;
	assign mem_done = (state == hci_pkg::st_mem) && mem_ack_in && ce_in;
	assign unack = cursor - 32'(FSB_BYTES * {29'h0, 3'(sent_count - last_nr)});
	assign cursor_load = mem_done && !mem_err_in && !op[10]
		&& (op[3:0] == hci_pkg::S_CUR_HI || op[3:0] == hci_pkg::S_CUR_LO);
	assign pready_out = ce_in;
	assign mem_space_out = space;

	always_comb begin
		src_word = 16'h0000;
		case (word_sel)
			hci_pkg::S_CUR_HI: src_word = cursor[31:16];
			hci_pkg::S_CUR_LO: src_word = cursor[15:0];
			hci_pkg::S_UNACK_HI: src_word = unack[31:16];
			hci_pkg::S_UNACK_LO: src_word = unack[15:0];
			hci_pkg::S_BASE_HI: src_word = base[31:16];
			hci_pkg::S_BASE_LO: src_word = base[15:0];
			hci_pkg::S_SPACE: src_word = {12'h000, space};
			hci_pkg::S_RX: src_word = {8'h00, rx_status};
			hci_pkg::S_TX: src_word = {8'h00, tx_status};
			default: src_word = 16'h0000;
		endcase
	end

	// =========================================
	// apb read path, sampled in the setup cycle
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			prdata_out <= 32'h00000000;
			pslverr_out <= 1'b0;
		end else if (ce_in && psel_in && !penable_in) begin
			pslverr_out <= !mapped;
			prdata_out <= 32'h00000000;
			if (paddr_in == hci_pkg::OFF_CMD)
				prdata_out <= {24'h000000, handshake};
			if (paddr_in == hci_pkg::OFF_VEC)
				prdata_out <= {24'h000000, iv};
			if (paddr_in == hci_pkg::OFF_STAT)
				prdata_out <= {15'h0000, fatal, tx_status, rx_status};
		end
	end

	// =========================================
	// command sequencer
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state <= hci_pkg::st_idle;
			cmd <= 8'h00;
			step <= 3'h0;
			op <= 12'h000;
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_addr_out <= 32'h00000000;
			mem_wdata_out <= 16'h0000;
		end else if (ce_in) begin
			case (state)
				hci_pkg::st_idle: begin
					if (cmd_go) begin
						cmd <= pwdata_in[7:0];
						step <= 3'h0;
						if (prog(pwdata_in[7:0], 3'h0) != 12'h000)
							state <= hci_pkg::st_load;
						else
							state <= hci_pkg::st_done;
					end
				end
				hci_pkg::st_load: begin
					op <= next_op;
					mem_we_out <= next_op[10];
					mem_addr_out <= base + {25'h0000000, next_op[9:4], 1'b0};
					// write data valid with the request: memory may answer at once
					mem_wdata_out <= src_word;
					state <= hci_pkg::st_mem;
					mem_req_out <= 1'b1;
				end
				hci_pkg::st_mem: begin
					if (mem_ack_in) begin
						mem_req_out <= 1'b0;
						step <= 3'(step + 3'h1);
						// an access error aborts the rest of the program
						if (mem_err_in || op[11])
							state <= hci_pkg::st_done;
						else
							state <= hci_pkg::st_load;
					end
				end
				hci_pkg::st_done: state <= hci_pkg::st_idle;
				default: state <= hci_pkg::st_idle;
			endcase
			if (state == hci_pkg::st_mem && !mem_ack_in)
				mem_wdata_out <= src_word;
		end
	end

	// =========================================
	// handshake register
	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			handshake <= hci_pkg::HS_READY;
		else if (ce_in) begin
			if (cmd_go)
				handshake <= hci_pkg::HS_ACCEPT;
			else if (state == hci_pkg::st_done)
				handshake <= hci_pkg::HS_READY;
		end
	end

	// =========================================
	// host-written registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			iv <= hci_pkg::VEC_RESET;
			iv_written <= 1'b0;
		end else if (wr_acc && paddr_in == hci_pkg::OFF_VEC) begin
			iv <= pwdata_in[7:0];
			iv_written <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			init_value <= 32'h00000000;
		else if (wr_acc && paddr_in == hci_pkg::OFF_DATA)
			init_value <= pwdata_in;
	end

	// =========================================
	// station table pointer and space code
	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			base <= 32'h00000000;
			space <= 4'h0;
		end else if (cmd_go) begin
			if (pwdata_in[7:0] == hci_pkg::CMD_LOAD_STATION_POINTER_CMD)
				base <= init_value;
			if (pwdata_in[7:0] == hci_pkg::CMD_LOAD_FUNCTION_CODE_CMD)
				space <= init_value[3:0];
		end
	end

	// =========================================
	// transmit cursor; the table copy is never written back here
	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			cursor <= 32'h00000000;
			sent_count <= 3'h0;
			last_nr <= 3'h0;
		end else if (ce_in) begin
			if (cursor_load && op[3:0] == hci_pkg::S_CUR_HI)
				cursor[31:16] <= mem_rdata_in;
			else if (cursor_load)
				cursor[15:0] <= mem_rdata_in;
			else if (frame_sent_in)
				cursor <= cursor + FSB_BYTES;
			if (frame_sent_in)
				sent_count <= 3'(sent_count + 3'h1);
			if (ack_valid_in)
				last_nr <= ack_nr_in;
		end
	end

	// =========================================
	// status bits: a set in the clearing cycle survives
	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			rx_status <= 8'h00;
			tx_status <= 8'h00;
			fatal <= 1'b0;
		end else if (ce_in) begin
			rx_status <= (rx_status & ~((mem_done && !mem_err_in
				&& op[3:0] == hci_pkg::S_RX_CLR) ? mem_rdata_in[7:0] : 8'h00))
				| rx_event_in
				| ((cmd_go && !cmd_valid(pwdata_in[7:0])) ? 8'(1 << hci_pkg::UNDEFINED_INSTRUCTION_FLAG_BIT)
				: 8'h00);
			tx_status <= (tx_status & ~((mem_done && !mem_err_in
				&& op[3:0] == hci_pkg::S_TX_CLR) ? mem_rdata_in[7:0] : 8'h00))
				| tx_event_in;
			if (mem_done && mem_err_in)
				fatal <= 1'b1;
		end
	end

	// =========================================
	// configuration and link controls
	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			station_cfg_out <= 2'h0;
			hw_cfg_out <= 4'h0;
			link_up_out <= 1'b0;
			loopback_out <= 1'b0;
			monitor_out <= 1'b0;
			dma_go_out <= 1'b0;
			continue_tx_out <= 1'b0;
		end else if (ce_in) begin
			dma_go_out <= cmd_go && pwdata_in[7:0] == hci_pkg::CMD_DMA;
			continue_tx_out <= cmd_go && pwdata_in[7:0] == hci_pkg::CMD_CONT_TX;
			if (cmd_go) begin
				if (pwdata_in[7:5] == hci_pkg::GRP_STN)
					station_cfg_out <= {pwdata_in[3], pwdata_in[1]};
				if (pwdata_in[7:5] == hci_pkg::GRP_HW)
					hw_cfg_out <= {pwdata_in[4:3], pwdata_in[1:0]};
				if (pwdata_in[7:0] == hci_pkg::CMD_START)
					link_up_out <= 1'b1;
				if (pwdata_in[7:0] == hci_pkg::CMD_STOP)
					link_up_out <= 1'b0;
				if (pwdata_in[7:0] == hci_pkg::CMD_LOOP)
					loopback_out <= 1'b1;
				if (pwdata_in[7:0] == hci_pkg::CMD_MON)
					monitor_out <= 1'b1;
				if (pwdata_in[7:0] == hci_pkg::CMD_END_MON)
					monitor_out <= 1'b0;
			end
		end
	end

	// =========================================
	// interrupt request and vector
	assign src = fatal ? hci_pkg::SRC_FATAL
		: (|rx_status && |tx_status) ? hci_pkg::SRC_BOTH
		: (|rx_status) ? hci_pkg::SRC_RX : hci_pkg::SRC_TX;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			iack_meta <= 1'b0;
			iack_sync <= 1'b0;
			iack_prev <= 1'b0;
			irq_out <= 1'b0;
			vector_out <= hci_pkg::VEC_RESET;
		end else if (ce_in) begin
			iack_meta <= iack_in;
			iack_sync <= iack_meta;
			iack_prev <= iack_sync;
			irq_out <= fatal || (|rx_status) || (|tx_status);
			if (iack_sync && !iack_prev)
				vector_out <= iv_written ? {iv[7:2], src} : hci_pkg::VEC_RESET;
		end
	end

	// =========================================
	// checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	a_cmd_accept_fe: assert property (cmd_go && !sw_rst |=> handshake == 8'hfe)
		else $error("command write did not show accept");
	a_done_ready_ff: assert property (ce_in && state == hci_pkg::st_done |=> handshake == 8'hff)
		else $error("completed command did not show ready");
	a_undef_flag: assert property (cmd_go && !cmd_valid(pwdata_in[7:0]) |=> rx_status[0])
		else $error("undefined command left flag clear");
	a_vector_default: assert property (ce_in && iack_sync && !iack_prev && !iv_written
		|=> vector_out == 8'h0f)
		else $error("default vector not supplied");
	a_vector_upper: assert property (ce_in && iack_sync && !iack_prev && iv_written && !rst_all
		|=> vector_out[7:2] == $past(iv[7:2]))
		else $error("vector upper bits not from register");
	a_fatal_source: assert property (ce_in && iack_sync && !iack_prev && iv_written && fatal
		&& !rst_all |=> vector_out[1:0] == 2'b11)
		else $error("fatal source not encoded");
	a_fatal_irq_held: assert property (fatal && ce_in |=> irq_out)
		else $error("fatal error lost its interrupt");
	a_stp_load: assert property (cmd_go && pwdata_in[7:0] == 8'h81
		|=> base == $past(init_value))
		else $error("station pointer not loaded");
	a_cursor_step: assert property (ce_in && frame_sent_in && !cursor_load && !rst_all
		|=> cursor == $past(cursor) + FSB_BYTES)
		else $error("cursor did not advance by one block");
	a_hw_cfg_bits: assert property (cmd_go && pwdata_in[7:5] == 3'b110
		|=> hw_cfg_out == {$past(pwdata_in[4:3]), $past(pwdata_in[1:0])})
		else $error("hardware configuration modifiers wrong");

	c_cmd_accepted: cover property (cmd_go ##[1:20] handshake == 8'hff);
	c_table_read: cover property (cursor_load ##[2:20] cursor_load);
	c_vector_given: cover property (iack_sync && !iack_prev && iv_written);

endmodule

// ===== sim/host_memory_model.sv
`timescale 1ns/1ps
module host_memory_model (
	// clock
	input wire logic clk_in,
	// shared memory port
	input wire logic req_in,
	input wire logic we_in,
	input wire logic [31:0] addr_in,
	input wire logic [15:0] wdata_in,
	output logic ack_out,
	output logic [15:0] rdata_out,
	output logic err_out,
	// test controls
	input wire logic [3:0] wait_in,
	input wire logic err_mode_in
);
	// =========================================
	// station table, 64 words, indexed by word address
	logic [15:0] words [0:63];
	logic [3:0] cnt = 4'h0;
	initial begin
		ack_out = 1'b0;
		err_out = 1'b0;
		rdata_out = 16'h0000;
	end
	// data lines toggle outside an ack so stale values never look valid
	always @(posedge clk_in) begin
		if (ack_out) begin
			ack_out <= 1'b0;
			err_out <= 1'b0;
			cnt <= 4'h0;
			rdata_out <= ~rdata_out;
		end else if (req_in && cnt == wait_in) begin
			ack_out <= 1'b1;
			err_out <= err_mode_in;
			if (we_in && !err_mode_in) words[addr_in[6:1]] <= wdata_in;
			else rdata_out <= words[addr_in[6:1]];
		end else begin
			if (req_in) cnt <= cnt + 4'h1;
			rdata_out <= ~rdata_out;
		end
	end
endmodule

// ===== sim/host_command_interface_tb.sv
`timescale 1ns/1ps
module host_command_interface_tb;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic mem_req_out, mem_we_out, mem_ack_in, mem_err_in;
	logic [31:0] mem_addr_out;
	logic [15:0] mem_wdata_out, mem_rdata_in;
	logic [3:0] mem_space_out;
	logic frame_sent_in = 1'b0;
	logic ack_valid_in = 1'b0;
	logic [2:0] ack_nr_in = 3'h0;
	logic [7:0] rx_event_in = 8'h00;
	logic [7:0] tx_event_in = 8'h00;
	logic iack_in = 1'b0;
	logic irq_out;
	logic [7:0] vector_out;
	logic [1:0] station_cfg_out;
	logic [3:0] hw_cfg_out;
	logic link_up_out, loopback_out, monitor_out, dma_go_out, continue_tx_out;
	// sticky record of the one-cycle command pulses
	logic [1:0] pulses = 2'h0;
	logic [3:0] mem_wait = 4'h0;
	logic err_mode = 1'b0;
	logic [31:0] rd;
	logic last_err;
	int num_errors = 0;
	int compares = 0;
	// {code, undefined flag expected}
	logic [8:0] rows [24] = '{9'h104, 9'h106, 9'h108, 9'h10c, 9'h10e, 9'h11a, 9'h11c, 9'h120,
		9'h122, 9'h124, 9'h126, 9'h12a, 9'h129, 9'h12d, 9'h0ff, 9'h140, 9'h17e, 9'h154,
		9'h180, 9'h1be, 9'h1b6, 9'h1c1, 9'h1fd, 9'h001};

	always #20 ref_clk_in = ~ref_clk_in;

	always @(posedge ref_clk_in) pulses <= pulses | {continue_tx_out, dma_go_out};

	host_command_interface uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(1'b1),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .mem_req_out(mem_req_out),
		.mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_space_out(mem_space_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
		.mem_err_in(mem_err_in), .frame_sent_in(frame_sent_in), .ack_valid_in(ack_valid_in),
		.ack_nr_in(ack_nr_in), .rx_event_in(rx_event_in), .tx_event_in(tx_event_in),
		.iack_in(iack_in), .irq_out(irq_out), .vector_out(vector_out),
		.station_cfg_out(station_cfg_out), .hw_cfg_out(hw_cfg_out), .link_up_out(link_up_out),
		.loopback_out(loopback_out), .monitor_out(monitor_out), .dma_go_out(dma_go_out),
		.continue_tx_out(continue_tx_out));

	host_memory_model mem (.clk_in(ref_clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
		.addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ack_out(mem_ack_in),
		.rdata_out(mem_rdata_in), .err_out(mem_err_in), .wait_in(mem_wait),
		.err_mode_in(err_mode));

	// =========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// idle cycle first so no signal is driven twice in one time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			close_out();
		end
		rd = prdata_out;
		last_err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			apb(1'b0, hci_pkg::OFF_CMD, 32'h0);
			n++;
		end while (rd[7:0] !== hci_pkg::HS_READY && n < 40);
		if (n >= 40) begin
			num_errors++;
			close_out();
		end
	endtask

	task automatic cmd(input logic [7:0] c);
		wait_ready();
		apb(1'b1, hci_pkg::OFF_CMD, {24'h0, c});
	endtask

	task automatic ev(input logic [7:0] r, input logic [7:0] t);
		@(posedge ref_clk_in);
		rx_event_in <= r;
		tx_event_in <= t;
		@(posedge ref_clk_in);
		rx_event_in <= 8'h00;
		tx_event_in <= 8'h00;
		repeat (3) @(posedge ref_clk_in);
	endtask

	task automatic iack_chk(input logic [7:0] e);
		@(posedge ref_clk_in);
		iack_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		iack_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		chk(vector_out, e);
	endtask

	// =========================================
	// main sequence
	initial begin
		logic [7:0] c;
		for (int i = 0; i < 64; i++) mem.words[i] = 16'h0000;
		mem.words[14] = 16'h1234;
		mem.words[15] = 16'h5600;
		mem.words[20] = 16'hffff;
		mem.words[21] = 16'hffff;
		repeat (4) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		chk(vector_out, 8'h0f);
		apb(1'b0, hci_pkg::OFF_VEC, 32'h0);
		chk(rd[7:0], 8'h0f);
		apb(1'b0, 8'h10, 32'h0);
		chk(last_err, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			c = rows[i][8:1];
			cmd(c);
			wait_ready();
			apb(1'b0, hci_pkg::OFF_STAT, 32'h0);
			chk(rd[0], rows[i][0]);
			if (c[7:5] == 3'b101) chk(station_cfg_out, {c[3], c[1]});
			if (c[7:5] == 3'b110) chk(hw_cfg_out, {c[4], c[3], c[1], c[0]});
			case (c)
				hci_pkg::CMD_START: chk(link_up_out, 1'b1);
				hci_pkg::CMD_STOP: chk(link_up_out, 1'b0);
				hci_pkg::CMD_DMA: chk(pulses, 2'b01);
				hci_pkg::CMD_LOOP: chk(loopback_out, 1'b1);
				hci_pkg::CMD_MON: chk(monitor_out, 1'b1);
				hci_pkg::CMD_END_MON: chk(monitor_out, 1'b0);
				hci_pkg::CMD_CONT_TX: chk(pulses, 2'b11);
				default: ;
			endcase
			if (rows[i][0]) cmd(hci_pkg::CMD_CLR_RX);
		end
		$display("test command table done");
		apb(1'b1, hci_pkg::OFF_DATA, 32'h00001000);
		cmd(hci_pkg::CMD_LOAD_STATION_POINTER_CMD);
		apb(1'b1, hci_pkg::OFF_DATA, 32'h0000000a);
		cmd(hci_pkg::CMD_LOAD_FUNCTION_CODE_CMD);
		wait_ready();
		chk(mem_space_out, 4'ha);
		mem_wait <= 4'h6;
		cmd(hci_pkg::CMD_LOAD_TTP);
		apb(1'b0, hci_pkg::OFF_CMD, 32'h0);
		chk(rd[7:0], 8'hfe);
		wait_ready();
		repeat (3) begin
			@(posedge ref_clk_in);
			frame_sent_in <= 1'b1;
			@(posedge ref_clk_in);
			frame_sent_in <= 1'b0;
		end
		// one frame acknowledged: two of three stay outstanding
		@(posedge ref_clk_in);
		ack_valid_in <= 1'b1;
		ack_nr_in <= 3'h1;
		@(posedge ref_clk_in);
		ack_valid_in <= 1'b0;
		cmd(hci_pkg::CMD_DUMP_PAR);
		cmd(hci_pkg::CMD_DUMP_REG);
		wait_ready();
		chk({mem.words[16], mem.words[17]}, 32'h12345630);
		chk({mem.words[18], mem.words[19]}, 32'h12345610);
		chk({mem.words[14], mem.words[15]}, 32'h12345600);
		chk({mem.words[32], mem.words[33]}, 32'h00001000);
		chk(mem.words[34], 16'h000a);
		chk({mem.words[35], mem.words[36]}, 32'h12345630);
		$display("test table commands done");
		apb(1'b1, hci_pkg::OFF_VEC, 32'h00000040);
		ev(8'h02, 8'h00);
		chk(irq_out, 1'b1);
		iack_chk(8'h41);
		ev(8'h00, 8'h04);
		iack_chk(8'h40);
		// memory answering at once: write data must come with the request
		mem_wait <= 4'h0;
		cmd(hci_pkg::CMD_UPDATE);
		wait_ready();
		chk(mem.words[22], 16'h0002);
		chk(mem.words[23], 16'h0004);
		mem_wait <= 4'h6;
		cmd(hci_pkg::CMD_CLR_ALL);
		wait_ready();
		chk(irq_out, 1'b0);
		ev(8'h00, 8'h01);
		iack_chk(8'h42);
		cmd(hci_pkg::CMD_CLR_TX);
		wait_ready();
		chk(irq_out, 1'b0);
		$display("test interrupt done");
		err_mode <= 1'b1;
		cmd(hci_pkg::CMD_LOAD_TTP);
		wait_ready();
		err_mode <= 1'b0;
		iack_chk(8'h43);
		cmd(hci_pkg::CMD_CLR_ALL);
		wait_ready();
		chk(irq_out, 1'b1);
		cmd(hci_pkg::CMD_SW_RESET);
		wait_ready();
		chk(irq_out, 1'b0);
		apb(1'b0, hci_pkg::OFF_VEC, 32'h0);
		chk(rd[7:0], 8'h0f);
		ev(8'h02, 8'h00);
		iack_chk(8'h0f);
		cmd(hci_pkg::CMD_DUMP_REG);
		wait_ready();
		chk({mem.words[32], mem.words[33]}, 32'h0);
		chk(mem.words[34], 16'h0000);
		chk({mem.words[35], mem.words[36]}, 32'h0);
		$display("test fatal and reset done");
		close_out();
	end
endmodule
